// ---- hrs_defines.svh ----
// hrs_defines.svh: shared constants of the hash request sequencer and its service end.
// assumes inclusion by bare name from every design file except the package file; holds definitions only.
`ifndef HRS_DEFINES_SVH
`define HRS_DEFINES_SVH
// hash service command and status codes
`define HRS_CMD_SHA256 8'h0a
`define HRS_ST_SUCCESS 8'h00
`define HRS_ST_BUS_ERR 8'h7f
`define HRS_ST_NOT_LICENSED 8'hfd
`define HRS_ST_FACTORY_OFF 8'hfe
`define HRS_ST_USER_OFF 8'hff
`define HRS_CMD_W 8
`define HRS_ST_W 8
// message and digest sizes
`define HRS_MSG_BYTES 64
`define HRS_MSG_W (`HRS_MSG_BYTES * 8)
`define HRS_DIG_W 256
`define HRS_SW_W 4
`define HRS_NIB_W 4
`define HRS_NIB_CNT (`HRS_DIG_W / `HRS_NIB_W)
`define HRS_NIB_CNT_W 7
// ascii hex mapping, lower-case letters
`define HRS_ASCII_ZERO 8'h30
`define HRS_ASCII_LOWA 8'h61
`define HRS_NIB_TEN 4'ha
// fabric clock and serial framing
`define HRS_CLK_HZ 100000000
`define HRS_BAUD 57600
`define HRS_BIT_CYC (`HRS_CLK_HZ / `HRS_BAUD)
`define HRS_BAUD_CNT_W 12
`define HRS_DATA_BITS 8
`define HRS_BIT_IDX_W 3
`define HRS_CHAR_W 8
// character buffer
`define HRS_FIFO_DEPTH 32
`endif

// ---- hrs_pkg.sv ----
// hrs_pkg.sv: state types shared by both ends of the hash request link.
// assumes hrs_defines.svh holds the numeric constants.
package hrs_pkg;
  // sequencer request states
  typedef enum logic [1:0] {
    HRS_SEQ_IDLE = 2'b00,
    HRS_SEQ_REQ = 2'b01,
    HRS_SEQ_WAIT = 2'b10
  } hrs_seq_state_t;
  // serial framing states, used by both transmitter and receiver
  typedef enum logic [1:0] {
    HRS_SER_IDLE = 2'b00,
    HRS_SER_START = 2'b01,
    HRS_SER_DATA = 2'b10,
    HRS_SER_STOP = 2'b11
  } hrs_ser_state_t;
  // service end states
  typedef enum logic [1:0] {
    HRS_SVC_IDLE = 2'b00,
    HRS_SVC_BUSY = 2'b01,
    HRS_SVC_RSP = 2'b10
  } hrs_svc_state_t;
endpackage

// ---- hrs_if.sv ----
// hrs_if.sv: link between the sequencer end and the service/controller end.
// assumes both ends run on the same fabric clock; no crossing inside.
`timescale 1ns/1ns
`include "hrs_defines.svh"
interface hrs_if;
  logic start; // controller asks for one hash run, level
  logic busy; // sequencer has taken a start
  logic reqValid; // hash request pending
  logic [`HRS_CMD_W-1:0] reqCmd; // service command code
  logic [`HRS_MSG_W-1:0] reqMsg; // message, byte 0 in the top bits
  logic reqAck; // service has taken the request, pulse
  logic rspValid; // response present, pulse
  logic [`HRS_ST_W-1:0] rspStatus; // response status byte
  logic [`HRS_DIG_W-1:0] rspDigest; // returned digest
  logic txd; // serial terminal data from the sequencer end
  modport seq (input start, reqAck, rspValid, rspStatus, rspDigest,
    output busy, reqValid, reqCmd, reqMsg, txd);
  modport svc (output start, reqAck, rspValid, rspStatus, rspDigest,
    input busy, reqValid, reqCmd, reqMsg, txd);
endinterface

// ---- hrs_seq_end.sv ----
// hrs_seq_end.sv: hash request sequencer, digest formatter, char buffer, serial sender.
// assumes one fabric clock for everything and a common active-low reset.
// Operation
// - message is a big-endian binary counter
// - top four message bits from board switches
// - counter steps once per successful hash
// - stepped counter feeds the next request
// - launch request, latch returned digest words
// - 64-byte message, 256-bit digest
// - formatter turns each nibble into ascii hex
// - hex digits 0-9 then lower-case a-f
// - serial 57600 baud, 8N1, no flow control
// - all logic on the 100 MHz fabric clock
// - one common reset drives every block except the char buffer storage
// - serial user request triggers the sequencer
// - start moves sequencer out of idle
// - hash command code 0x0a, byte mode
// - status 0 success, 127 and 253-255 failures
`timescale 1ns/1ns
`include "hrs_defines.svh"

module hrs_seq_end #(
  parameter int BIT_CYC = `HRS_BIT_CYC, // cycles per serial bit
  parameter int FIFO_DEPTH = `HRS_FIFO_DEPTH
) (
  input wire logic clk, // fabric clock
  input wire logic rst_n, // common reset
  input wire logic ce,
  input wire logic [`HRS_SW_W-1:0] boardSwitchInput,
  hrs_if.seq link,
  output logic [`HRS_DIG_W-1:0] digestOut,
  output logic digestValid,
  output logic [`HRS_ST_W-1:0] lastStatus
);
  localparam int CNT_W = `HRS_MSG_W - `HRS_SW_W;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [`HRS_BAUD_CNT_W-1:0] BIT_LAST = `HRS_BAUD_CNT_W'(BIT_CYC - 1);

  hrs_pkg::hrs_seq_state_t state_r; // request sequencer state
  logic [`HRS_SW_W-1:0] swMeta_r; // first sync stage, read by swSync_r only
  logic [`HRS_SW_W-1:0] swSync_r;
  logic [CNT_W-1:0] count_r; // message counter, low part
  logic busy_r;
  logic reqValid_r;
  logic [`HRS_MSG_W-1:0] reqMsg_r;
  logic [`HRS_DIG_W-1:0] digest_r;
  logic digestValid_r;
  logic [`HRS_ST_W-1:0] status_r;
  logic [`HRS_DIG_W-1:0] fmtShift_r; // digest being spelled out, top nibble first
  logic [`HRS_NIB_CNT_W-1:0] fmtLeft_r; // nibbles still to emit
  logic [`HRS_CHAR_W-1:0] fmtChar;
  logic [`HRS_NIB_W-1:0] fmtNib;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [`HRS_CHAR_W-1:0] fifoOutData;
  hrs_pkg::hrs_ser_state_t txState_r;
  logic [`HRS_BAUD_CNT_W-1:0] txBaud_r;
  logic [`HRS_BIT_IDX_W-1:0] txBit_r;
  logic [`HRS_CHAR_W-1:0] txShift_r;
  logic txd_r;
  logic acceptStart;
  logic gotRsp;
  logic okRsp;
  logic fmtPush;

  // start is taken only when idle and the previous digest is spelled out
  assign acceptStart = ce && (state_r == hrs_pkg::HRS_SEQ_IDLE) && link.start && (fmtLeft_r == '0);
  assign gotRsp = ce && (state_r == hrs_pkg::HRS_SEQ_WAIT) && link.rspValid;
  assign okRsp = gotRsp && (link.rspStatus == `HRS_ST_SUCCESS);

  // switch pins are asynchronous: two stages before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swMeta_r <= '0;
      swSync_r <= '0;
    end else if (ce) begin
      swMeta_r <= boardSwitchInput;
      swSync_r <= swMeta_r;
    end
  end

  // request handshake state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= hrs_pkg::HRS_SEQ_IDLE;
      busy_r <= 1'b0;
      reqValid_r <= 1'b0;
      reqMsg_r <= '0;
    end else if (ce) begin
      unique case (state_r)
        hrs_pkg::HRS_SEQ_IDLE: begin
          if (acceptStart) begin
            // top bits follow switches, rest is the counter, byte 0 highest
            reqMsg_r <= {swSync_r, count_r};
            reqValid_r <= 1'b1;
            busy_r <= 1'b1;
            state_r <= hrs_pkg::HRS_SEQ_REQ;
          end
        end
        hrs_pkg::HRS_SEQ_REQ: begin
          // request stays up until acknowledged
          if (link.reqAck) begin
            reqValid_r <= 1'b0;
            state_r <= hrs_pkg::HRS_SEQ_WAIT;
          end
        end
        hrs_pkg::HRS_SEQ_WAIT: begin
          // any status ends the run; failures go back idle too
          if (link.rspValid) begin
            busy_r <= 1'b0;
            state_r <= hrs_pkg::HRS_SEQ_IDLE;
          end
        end
        default: begin
          state_r <= hrs_pkg::HRS_SEQ_IDLE;
          busy_r <= 1'b0;
          reqValid_r <= 1'b0;
        end
      endcase
    end
  end

  // counter steps only on a good digest
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (okRsp) begin
      count_r <= count_r + CNT_ONE;
    end
  end

  // digest and status capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digest_r <= '0;
      digestValid_r <= 1'b0;
      status_r <= `HRS_ST_SUCCESS;
    end else if (ce) begin
      digestValid_r <= okRsp;
      if (gotRsp) begin
        status_r <= link.rspStatus;
      end
      if (okRsp) begin
        digest_r <= link.rspDigest;
      end
    end
  end

  // nibble to ascii hex
  assign fmtNib = fmtShift_r[`HRS_DIG_W-1 -: `HRS_NIB_W];
  always_comb begin
    if (fmtNib < `HRS_NIB_TEN) begin
      fmtChar = `HRS_ASCII_ZERO + {4'h0, fmtNib};
    end else begin
      fmtChar = `HRS_ASCII_LOWA + {4'h0, fmtNib - `HRS_NIB_TEN};
    end
  end
  assign fmtPush = ce && (fmtLeft_r != '0) && fifoInReady;

  // formatter: loads a good digest, pushes one char per nibble
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmtShift_r <= '0;
      fmtLeft_r <= '0;
    end else if (ce) begin
      if (okRsp) begin
        fmtShift_r <= link.rspDigest;
        fmtLeft_r <= `HRS_NIB_CNT_W'(`HRS_NIB_CNT);
      end else if (fmtPush) begin
        fmtShift_r <= {fmtShift_r[`HRS_DIG_W-`HRS_NIB_W-1:0], `HRS_NIB_W'(0)};
        fmtLeft_r <= fmtLeft_r - 1'b1;
      end
    end
  end

  // buffer between formatter and the slow serial line
  hrs_fifo #(.WIDTH(`HRS_CHAR_W), .DEPTH(FIFO_DEPTH)) charBuf (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .inValid(fmtLeft_r != '0),
    .inReady(fifoInReady),
    .inData(fmtChar),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // sender takes a char only when idle, so the buffer backs up
  assign fifoOutReady = (txState_r == hrs_pkg::HRS_SER_IDLE);

  // serial sender, 8 data bits, 1 stop, no parity
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_r <= hrs_pkg::HRS_SER_IDLE;
      txBaud_r <= '0;
      txBit_r <= '0;
      txShift_r <= '0;
      txd_r <= 1'b1;
    end else if (ce) begin
      unique case (txState_r)
        hrs_pkg::HRS_SER_IDLE: begin
          txd_r <= 1'b1;
          if (fifoOutValid) begin
            txShift_r <= fifoOutData;
            txd_r <= 1'b0; // start bit
            txBaud_r <= '0;
            txState_r <= hrs_pkg::HRS_SER_START;
          end
        end
        hrs_pkg::HRS_SER_START: begin
          if (txBaud_r == BIT_LAST) begin
            txBaud_r <= '0;
            txBit_r <= '0;
            txd_r <= txShift_r[0]; // lsb first
            txState_r <= hrs_pkg::HRS_SER_DATA;
          end else begin
            txBaud_r <= txBaud_r + 1'b1;
          end
        end
        hrs_pkg::HRS_SER_DATA: begin
          if (txBaud_r == BIT_LAST) begin
            txBaud_r <= '0;
            if (txBit_r == `HRS_BIT_IDX_W'(`HRS_DATA_BITS - 1)) begin
              txd_r <= 1'b1; // stop bit
              txState_r <= hrs_pkg::HRS_SER_STOP;
            end else begin
              txBit_r <= txBit_r + 1'b1;
              txShift_r <= {1'b0, txShift_r[`HRS_CHAR_W-1:1]};
              txd_r <= txShift_r[1];
            end
          end else begin
            txBaud_r <= txBaud_r + 1'b1;
          end
        end
        hrs_pkg::HRS_SER_STOP: begin
          if (txBaud_r == BIT_LAST) begin
            txBaud_r <= '0;
            txState_r <= hrs_pkg::HRS_SER_IDLE;
          end else begin
            txBaud_r <= txBaud_r + 1'b1;
          end
        end
      endcase
    end
  end

  assign link.busy = busy_r;
  assign link.reqValid = reqValid_r;
  assign link.reqCmd = `HRS_CMD_SHA256;
  assign link.reqMsg = reqMsg_r;
  assign link.txd = txd_r;
  assign digestOut = digest_r;
  assign digestValid = digestValid_r;
  assign lastStatus = status_r;
endmodule

// ---- hrs_svc_end.sv ----
// hrs_svc_end.sv: controller and service-core end of the hash request link, plus the char buffer.
// assumes the hash engine sits on the user side on the same fabric clock.
`timescale 1ns/1ns
`include "hrs_defines.svh"
module hrs_svc_end #(
  parameter int BIT_CYC = `HRS_BIT_CYC // cycles per serial bit
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic termRxd, // serial from the terminal, asynchronous
  output logic termTxd, // serial to the terminal
  output logic [`HRS_CHAR_W-1:0] rxByte,
  output logic rxValid,
  output logic [`HRS_MSG_W-1:0] engMsg,
  output logic engGo,
  input wire logic engDone,
  input wire logic [`HRS_ST_W-1:0] engStatus,
  input wire logic [`HRS_DIG_W-1:0] engDigest,
  hrs_if.svc link
);
  localparam logic [`HRS_BAUD_CNT_W-1:0] BIT_LAST = `HRS_BAUD_CNT_W'(BIT_CYC - 1);
  localparam logic [`HRS_BAUD_CNT_W-1:0] BIT_HALF = `HRS_BAUD_CNT_W'(BIT_CYC / 2);

  hrs_pkg::hrs_svc_state_t state_r;
  hrs_pkg::hrs_ser_state_t rxState_r;
  logic rxMeta_r; // first sync stage, read by rxSync_r only
  logic rxSync_r;
  logic [`HRS_BAUD_CNT_W-1:0] rxBaud_r;
  logic [`HRS_BIT_IDX_W-1:0] rxBit_r;
  logic [`HRS_CHAR_W-1:0] rxShift_r;
  logic [`HRS_CHAR_W-1:0] rxByte_r;
  logic rxValid_r;
  logic start_r;
  logic reqAck_r;
  logic rspValid_r;
  logic [`HRS_ST_W-1:0] rspStatus_r;
  logic [`HRS_DIG_W-1:0] rspDigest_r;
  logic [`HRS_MSG_W-1:0] engMsg_r;
  logic engGo_r;
  logic termTxd_r;

  // terminal line is asynchronous: two stages; also pass device serial out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      termTxd_r <= 1'b1;
    end else if (ce) begin
      rxMeta_r <= termRxd;
      rxSync_r <= rxMeta_r;
      termTxd_r <= link.txd;
    end
  end

  // serial receiver, centre sampling, 8N1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= hrs_pkg::HRS_SER_IDLE;
      rxBaud_r <= '0;
      rxBit_r <= '0;
      rxShift_r <= '0;
      rxByte_r <= '0;
      rxValid_r <= 1'b0;
    end else if (ce) begin
      rxValid_r <= 1'b0;
      unique case (rxState_r)
        hrs_pkg::HRS_SER_IDLE: begin
          if (!rxSync_r) begin
            rxBaud_r <= '0;
            rxState_r <= hrs_pkg::HRS_SER_START;
          end
        end
        hrs_pkg::HRS_SER_START: begin
          // glitch shorter than half a bit is dropped
          if (rxBaud_r == BIT_HALF) begin
            rxBaud_r <= '0;
            rxBit_r <= '0;
            rxState_r <= rxSync_r ? hrs_pkg::HRS_SER_IDLE : hrs_pkg::HRS_SER_DATA;
          end else begin
            rxBaud_r <= rxBaud_r + 1'b1;
          end
        end
        hrs_pkg::HRS_SER_DATA: begin
          if (rxBaud_r == BIT_LAST) begin
            rxBaud_r <= '0;
            rxShift_r <= {rxSync_r, rxShift_r[`HRS_CHAR_W-1:1]};
            if (rxBit_r == `HRS_BIT_IDX_W'(`HRS_DATA_BITS - 1)) begin
              rxState_r <= hrs_pkg::HRS_SER_STOP;
            end else begin
              rxBit_r <= rxBit_r + 1'b1;
            end
          end else begin
            rxBaud_r <= rxBaud_r + 1'b1;
          end
        end
        hrs_pkg::HRS_SER_STOP: begin
          if (rxBaud_r == BIT_LAST) begin
            rxBaud_r <= '0;
            rxState_r <= hrs_pkg::HRS_SER_IDLE;
            // framing error byte is discarded
            if (rxSync_r) begin
              rxByte_r <= rxShift_r;
              rxValid_r <= 1'b1;
            end
          end else begin
            rxBaud_r <= rxBaud_r + 1'b1;
          end
        end
      endcase
    end
  end

  // start held from a received byte until the sequencer shows busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 1'b0;
    end else if (ce) begin
      if (rxValid_r) begin
        start_r <= 1'b1;
      end else if (link.busy) begin
        start_r <= 1'b0;
      end
    end
  end

  // service side of the request handshake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= hrs_pkg::HRS_SVC_IDLE;
      reqAck_r <= 1'b0;
      rspValid_r <= 1'b0;
      rspStatus_r <= `HRS_ST_SUCCESS;
      rspDigest_r <= '0;
      engMsg_r <= '0;
      engGo_r <= 1'b0;
    end else if (ce) begin
      reqAck_r <= 1'b0;
      rspValid_r <= 1'b0;
      engGo_r <= 1'b0;
      unique case (state_r)
        hrs_pkg::HRS_SVC_IDLE: begin
          if (link.reqValid) begin
            reqAck_r <= 1'b1;
            if (link.reqCmd == `HRS_CMD_SHA256) begin
              engMsg_r <= link.reqMsg;
              engGo_r <= 1'b1;
              state_r <= hrs_pkg::HRS_SVC_BUSY;
            end else begin
              // unknown command answered as an unavailable service
              rspStatus_r <= `HRS_ST_NOT_LICENSED;
              state_r <= hrs_pkg::HRS_SVC_RSP;
            end
          end
        end
        hrs_pkg::HRS_SVC_BUSY: begin
          if (engDone) begin
            rspStatus_r <= engStatus;
            rspDigest_r <= engDigest;
            rspValid_r <= 1'b1;
            state_r <= hrs_pkg::HRS_SVC_IDLE;
          end
        end
        hrs_pkg::HRS_SVC_RSP: begin
          rspValid_r <= 1'b1;
          state_r <= hrs_pkg::HRS_SVC_IDLE;
        end
        default: begin
          state_r <= hrs_pkg::HRS_SVC_IDLE;
        end
      endcase
    end
  end

  assign link.start = start_r;
  assign link.reqAck = reqAck_r;
  assign link.rspValid = rspValid_r;
  assign link.rspStatus = rspStatus_r;
  assign link.rspDigest = rspDigest_r;
  assign termTxd = termTxd_r;
  assign rxByte = rxByte_r;
  assign rxValid = rxValid_r;
  assign engMsg = engMsg_r;
  assign engGo = engGo_r;
endmodule

// parameterised character buffer with valid/ready on both sides, used by the sequencer end
module hrs_fifo #(
  parameter int WIDTH = `HRS_CHAR_W,
  parameter int DEPTH = `HRS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
  logic [AW:0] wrPtr_r; // extra bit tells full from empty
  logic [AW:0] rdPtr_r;
  logic doWr;
  logic doRd;

  assign inReady = (wrPtr_r[AW] == rdPtr_r[AW]) || (wrPtr_r[AW-1:0] != rdPtr_r[AW-1:0]);
  assign outValid = wrPtr_r != rdPtr_r;
  assign outData = mem[rdPtr_r[AW-1:0]];
  assign doWr = ce && inValid && inReady;
  assign doRd = ce && outValid && outReady;

  // write side
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (doWr) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule

// ---- hrs_link_chk.sv ----
// hrs_link_chk.sv: concurrent checks on the link between the sequencer end and the service end.
// assumes the bench instantiates it beside hrs_if and passes the link signals by name.
`timescale 1ns/1ns
`include "hrs_defines.svh"
module hrs_link_chk #(
  parameter int BIT_CYC = `HRS_BIT_CYC // cycles per serial bit, same as both ends
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic reqValid,
  input wire logic [`HRS_CMD_W-1:0] reqCmd,
  input wire logic [`HRS_MSG_W-1:0] reqMsg,
  input wire logic reqAck,
  input wire logic rspValid,
  input wire logic txd
);
  // length of the current low run on the serial line
  logic [15:0] lowRun_r;

  // counting runs instead of long repetitions keeps the tools fast
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowRun_r <= 16'h0000;
    end else begin
      lowRun_r <= txd ? 16'h0000 : lowRun_r + 16'h0001;
    end
  end

  a_req_held: assert property (@(posedge clk) disable iff (!rst_n)
    reqValid && !reqAck |=> reqValid && $stable(reqMsg))
    else $error("request dropped or changed before ack");
  a_ack_drop: assert property (@(posedge clk) disable iff (!rst_n)
    reqAck |=> !reqValid && !reqAck)
    else $error("request still up after ack");
  a_ack_soon: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(reqValid) |-> ##1 reqAck)
    else $error("request not acked in one cycle");
  a_cmd_code: assert property (@(posedge clk) disable iff (!rst_n)
    reqValid |-> reqCmd == 8'h0a)
    else $error("wrong command code");
  a_busy_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(reqValid) |-> $rose(busy))
    else $error("busy and request not raised together");
  a_req_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !busy |-> !reqValid)
    else $error("request while not busy");
  a_rsp_end: assert property (@(posedge clk) disable iff (!rst_n)
    rspValid |-> busy && !reqValid ##1 !busy && !rspValid)
    else $error("response outside a run");
  a_bit_time: assert property (@(posedge clk) disable iff (!rst_n)
    txd && lowRun_r != 16'h0000 |-> lowRun_r % BIT_CYC == 0 && lowRun_r <= 9 * BIT_CYC)
    else $error("serial low run off the bit grid");
endmodule

// ---- tb_top.sv ----
// tb_top.sv: bench joining the sequencer end and the service end over hrs_if.
// assumes the design files and hrs_link_chk.sv are compiled before it.
`timescale 1ns/1ns
`include "hrs_defines.svh"
module tb_top;
  localparam int BC = 8; // shortened bit time, same on both ends
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1; // both ends share one enable, dropped for a few cycles in each hash run
  logic rxd = 1'b1; // terminal line idles high
  logic [3:0] sw = 4'h0; // board switches
  logic engDone = 1'b0; // engine model result strobe
  logic [7:0] engStatus = 8'h00;
  logic [255:0] engDigest = 256'h0;
  logic [255:0] digestOut;
  logic digestValid;
  logic [7:0] lastStatus;
  logic [7:0] rxByte;
  logic rxValid;
  logic [511:0] engMsg;
  logic engGo;
  logic termTxd;
  logic [15:0] lfsr = 16'hc4b1; // random source
  logic [507:0] cnt = 508'h0; // model of the message counter
  logic [255:0] lastDig = 256'h0; // model of the kept digest
  logic [7:0] sent = 8'h00; // last byte sent by the terminal
  logic [7:0] ch; // character being decoded
  logic [7:0] rxq[$]; // characters seen by the terminal
  logic [7:0] stList[6] = '{8'h00, 8'h7f, 8'h00, 8'hfd, 8'hfe, 8'hff};
  int badCount = 0;
  int samplesChecked = 0;

  hrs_if link ();
  hrs_seq_end #(.BIT_CYC(BC), .FIFO_DEPTH(32)) u_hrs_seq_end (.clk(clk), .rst_n(rst_n), .ce(ce),
    .boardSwitchInput(sw), .link(link), .digestOut(digestOut), .digestValid(digestValid),
    .lastStatus(lastStatus));
  hrs_svc_end #(.BIT_CYC(BC)) u_hrs_svc_end (.clk(clk), .rst_n(rst_n), .ce(ce), .termRxd(rxd),
    .termTxd(termTxd), .rxByte(rxByte), .rxValid(rxValid), .engMsg(engMsg), .engGo(engGo),
    .engDone(engDone), .engStatus(engStatus), .engDigest(engDigest), .link(link));
  hrs_link_chk #(.BIT_CYC(BC)) u_hrs_link_chk (.clk(clk), .rst_n(rst_n), .busy(link.busy),
    .reqValid(link.reqValid), .reqCmd(link.reqCmd), .reqMsg(link.reqMsg), .reqAck(link.reqAck),
    .rspValid(link.rspValid), .txd(link.txd));

  // 50 MHz bench clock
  always #10 clk = ~clk;

  // step the random source
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // one edge, then a fixed settle delay before driving or sampling
  task tick;
    @(posedge clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [511:0] seen, input logic [511:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task giveVerdict;
    if (badCount == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a wait ran out of its bound
  task hang(input string what);
    badCount++;
    $display("unexpected %s: expected event, seen timeout", what);
    giveVerdict;
  endtask

  // terminal sends one frame; stop level is simply the idle level
  task automatic sendByte(input logic [7:0] b);
    sent = b;
    rxd = 1'b0;
    repeat (BC) tick;
    for (int i = 0; i < 8; i++) begin
      rxd = b[i];
      repeat (BC) tick;
    end
    rxd = 1'b1;
  endtask

  // received command byte must match what the terminal sent
  always @(posedge clk) begin
    #2;
    if (rxValid === 1'b1) chk("rxByte", rxByte, sent);
  end

  // terminal receiver, samples mid bit
  initial forever begin
    tick;
    if (rst_n === 1'b1 && termTxd === 1'b0) begin
      repeat (BC / 2) tick;
      for (int i = 0; i < 8; i++) begin
        repeat (BC) tick;
        ch[i] = termTxd;
      end
      repeat (BC) tick;
      chk("stop bit", termTxd, 1'b1);
      rxq.push_back(ch);
    end
  end

  // one whole hash run, engine answering with status st
  task automatic runHash(input logic [7:0] st);
    logic [15:0] r;
    logic [255:0] dig;
    logic [3:0] nib;
    logic seen;
    int k;
    int n;
    r = rnd();
    sw = r[3:0];
    for (k = 0; k < 16; k++) begin
      dig[k*16 +: 16] = rnd();
    end
    r = rnd();
    rxq.delete();
    sendByte(r[7:0]);
    for (k = 0; k < 200 && link.reqValid !== 1'b1; k++) tick;
    if (k == 200) hang("request");
    chk("reqMsg", link.reqMsg, {sw, cnt});
    for (k = 0; k < 20 && engGo !== 1'b1; k++) tick;
    if (k == 20) hang("engGo");
    chk("engMsg", engMsg, {sw, cnt});
    repeat (r[12:8]) tick; // engine time varies run to run
    tick; // let the ack pulse pass before freezing
    ce = 1'b0; // a strobe while frozen must be ignored
    engDone = 1'b1;
    engStatus = ~st;
    tick;
    engDone = 1'b0;
    repeat (3) tick;
    chk("frozen busy", link.busy, 1'b1);
    ce = 1'b1;
    engDone = 1'b1;
    engStatus = st;
    engDigest = dig;
    tick;
    engDone = 1'b0;
    engDigest = ~dig; // result lines no longer meaningful
    seen = 1'b0;
    for (k = 0; k < 8; k++) begin
      tick;
      if (digestValid === 1'b1) seen = 1'b1;
    end
    if (st == 8'h00) begin
      lastDig = dig;
      cnt = cnt + 508'h1;
    end
    chk("lastStatus", lastStatus, st);
    chk("digestValid", seen, st == 8'h00);
    chk("digestOut", digestOut, lastDig);
    n = (st == 8'h00) ? 64 : 0;
    for (k = 0; k < 8000 && rxq.size() < n; k++) tick;
    if (k == 8000) hang("characters");
    repeat (100) tick;
    chk("char count", rxq.size(), n);
    for (k = 0; k < n; k++) begin
      nib = lastDig[255-4*k -: 4];
      chk("char", rxq[k], nib < 4'ha ? 8'h30 + nib : 8'h61 + nib - 8'h0a);
    end
  endtask

  // main sequence: good and failed runs, then a reset in mid-run
  initial begin
    repeat (12) @(posedge clk);
    #2;
    rst_n = 1'b1;
    repeat (2) tick;
    foreach (stList[i]) runHash(stList[i]);
    sendByte(8'h5a);
    repeat (20) tick;
    rst_n = 1'b0;
    repeat (3) tick;
    rst_n = 1'b1;
    cnt = 508'h0;
    lastDig = 256'h0;
    chk("busy after reset", link.busy, 1'b0);
    chk("digest after reset", digestOut, 256'h0);
    repeat (2) tick;
    runHash(8'h00);
    giveVerdict;
  end
endmodule
